// ---- design/boot_map.svh ----
// timing, image and layout constants of the boot sequencer
`ifndef BOOT_MAP_SVH
`define BOOT_MAP_SVH
`define BL_CLK_NS 8
`define BL_CLK_KHZ 125000
`define BL_IRST_US 15
`define BL_IRST_CYC ((`BL_IRST_US * 1000 + `BL_CLK_NS - 1) / `BL_CLK_NS)
`define BL_LINK_NS 200
`define BL_LINK_CYC ((`BL_LINK_NS + `BL_CLK_NS - 1) / `BL_CLK_NS)
`define BL_SCLK_KHZ 2500
`define BL_SCLK_HALF (`BL_CLK_KHZ / (2 * `BL_SCLK_KHZ))
`define BL_SPI_READ 8'h03
`define BL_SPI_CMD_BYTES 16'h0004
`define BL_NO_CRC 32'h0D15_AB1E
`define BL_NULL_CHAN 32'h0000_FF02
`define BL_CRC_POLY 32'hEDB8_8320
`define BL_CRC_INIT 32'hFFFF_FFFF
`define BL_RAM_BASE 14'h0000
`define BL_OTP_BASE 13'h0000
`define BL_SEC_BOOT_BIT 5
`endif

// ---- design/boot_pkg.sv ----
// types shared by the boot sequencer modules
package boot_pkg;
  typedef enum logic [3:0] {
    S_HOLD, S_IRST, S_SELECT, S_JTAG, S_LINK_WAIT, S_SPI_CMD, S_ACK, S_SIZE,
    S_PROG, S_CRC, S_END_IN, S_END_OUT, S_RUN, S_FAIL
  } boot_state_t;
  typedef enum logic [1:0] {SRC_NONE, SRC_SPI, SRC_LINK, SRC_OTP} boot_src_t;
endpackage : boot_pkg

// ---- design/byte_buf2.sv ----
// two-entry buffer between the byte sources and the image parser
`timescale 1ns/1ps
module byte_buf2 (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  byte_if.snk in_s,
  byte_if.src out_s
);
  typedef struct packed {
    logic [8:0] m0;
    logic [8:0] m1;
    logic [1:0] cnt;
  } buf_t;
  buf_t q, d;
  logic push, pop;

  ////////////////////////////////////////////////////////////////////////
  // full at two entries; ready drops so the source stalls instead of losing
  assign in_s.ready = (q.cnt != 2'd2);
  assign out_s.valid = (q.cnt != 2'd0);
  assign out_s.data = q.m0;
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  // head always sits in m0
  always_comb begin
    d = q;
    unique case ({push, pop})
      2'b10: begin
        if (q.cnt == 2'd0) d.m0 = in_s.data;
        else d.m1 = in_s.data;
        d.cnt = q.cnt + 2'd1;
      end
      2'b01: begin
        d.m0 = q.m1;
        d.cnt = q.cnt - 2'd1;
      end
      2'b11: begin
        if (q.cnt == 2'd1) begin
          d.m0 = in_s.data;
        end else begin
          d.m0 = q.m1;
          d.m1 = in_s.data;
        end
      end
      2'b00: d = q;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) q <= '0;
    else if (ce) q <= d;
  end
endmodule : byte_buf2

// ---- design/byte_if.sv ----
// byte stream with valid and ready; bit 8 marks a control token
`timescale 1ns/1ps
interface byte_if;
  logic valid;
  logic ready;
  logic [8:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_if

// ---- design/multi_source_boot_loader.sv ----
// boot sequencer: selects a source, fetches and checks the image, loads ram, starts it
`timescale 1ns/1ps
`include "boot_map.svh"
module multi_source_boot_loader (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  input wire logic CHIP_RST_N,
  input wire logic [2:0] BOOT_SEL,
  input wire logic [31:0] SECURITY_REG,
  output logic GPIO_HIZ,
  output logic GPIO_PULL_EN,
  output logic BOOT_WAIT_JTAG,
  output logic BOOT_SEL_RESERVED,
  output logic TILE1_VIA_CHAN0,
  output logic INT_LINKS_EN,
  input wire logic SPI_MISO,
  output logic SPI_SS_N,
  output logic SPI_SCLK,
  output logic SPI_MOSI,
  output logic LINK_EN,
  output logic LINK_PD_EN,
  output logic [1:0] LINK_TX_WIRE,
  output logic LINK_TX_OE_N,
  output logic CHAN0_ALLOC,
  input wire logic LINK_RX_VALID,
  input wire logic [7:0] LINK_RX_DATA,
  input wire logic LINK_RX_CTRL,
  output logic LINK_RX_READY,
  output logic LINK_TX_VALID,
  output logic [31:0] LINK_TX_DEST,
  input wire logic LINK_TX_READY,
  output logic OTP_RD,
  output logic [12:0] OTP_ADDR,
  input wire logic OTP_VALID,
  input wire logic [7:0] OTP_DATA,
  output logic RAM_WE,
  output logic [13:0] RAM_ADDR,
  output logic [31:0] RAM_WDATA,
  output logic START_EXEC,
  output logic [13:0] START_ADDR,
  output logic CRC_ERROR,
  output logic BOOT_FAIL
);
  import boot_pkg::*;

  // all zero is the reset value of every field
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic [2:0] sel_s1;
    logic [2:0] sel_s2;
    logic miso_s1;
    logic miso_s2;
    boot_state_t st;
    boot_src_t src;
    logic [15:0] cnt;
    logic [1:0] bidx;
    logic [31:0] word;
    logic [31:0] left;
    logic [31:0] crc;
    logic [31:0] ack;
    logic [13:0] addr;
    logic [12:0] otp_next;
    logic [12:0] otp_ra;
    logic otp_rd;
    logic otp_pend;
    logic spi_go;
    logic spi_discard;
    logic [7:0] spi_tx;
    logic ss_act;
    logic gpio_rel;
    logic pull_en;
    logic link_en;
    logic chan_alloc;
    logic jtag_wait;
    logic reserved;
    logic tile1_chan;
    logic int_links;
    logic ram_we;
    logic [13:0] ram_addr;
    logic [31:0] ram_data;
    logic exec;
    logic crc_err;
    logic fail;
    logic tx_valid;
  } boot_reg_t;
  boot_reg_t q, d;

  byte_if buf_in ();
  byte_if buf_out ();
  byte_if spi_rx ();
  logic spi_busy;
  logic fetch_st;
  logic link_st;
  logic pop;

  ////////////////////////////////////////////////////////////////////////
  // reflected crc-32 step over one byte
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h00_0000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `BL_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  ////////////////////////////////////////////////////////////////////////
  // byte sources share one buffer; only the selected source sees ready
  assign fetch_st = (q.st == S_SIZE) || (q.st == S_PROG) || (q.st == S_CRC);
  assign link_st = fetch_st || (q.st == S_ACK) || (q.st == S_END_IN);
  assign buf_in.valid = (q.src == SRC_SPI) ? spi_rx.valid :
                        (q.src == SRC_LINK) ? (LINK_RX_VALID && link_st) :
                        (q.src == SRC_OTP) ? OTP_VALID : 1'b0;
  assign buf_in.data = (q.src == SRC_SPI) ? spi_rx.data :
                       (q.src == SRC_LINK) ? {LINK_RX_CTRL, LINK_RX_DATA} :
                       {1'b0, OTP_DATA};
  assign spi_rx.ready = (q.src == SRC_SPI) && buf_in.ready;
  assign LINK_RX_READY = (q.src == SRC_LINK) && link_st && buf_in.ready;
  assign buf_out.ready = link_st;
  assign pop = buf_out.valid && buf_out.ready;

  byte_buf2 u_buf (
    .clk(CLK_SYS),
    .rst(RST || !q.rst_s2), // chip reset also drops any byte left in flight
    .ce(CE),
    .in_s(buf_in.snk),
    .out_s(buf_out.src)
  );

  // the serial clock and data-out pins are wired here; the select pin comes from q.ss_act
  spi_boot_master u_spi (
    .clk(CLK_SYS),
    .rst(RST || !q.rst_s2),
    .ce(CE),
    .go(q.spi_go),
    .discard(q.spi_discard),
    .tx(q.spi_tx),
    .miso(q.miso_s2),
    .busy(spi_busy),
    .sclk(SPI_SCLK),
    .mosi(SPI_MOSI),
    .rx(spi_rx.src)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    logic [31:0] w;
    logic last;
    logic fin;
    w = {buf_out.data[7:0], q.word[31:8]};
    last = (q.bidx == 2'd3);
    fin = 1'b0;
    d = q;
    d.rst_s1 = CHIP_RST_N;
    d.rst_s2 = q.rst_s1;
    d.sel_s1 = BOOT_SEL;
    d.sel_s2 = q.sel_s1;
    d.miso_s1 = SPI_MISO;
    d.miso_s2 = q.miso_s1;
    d.ram_we = 1'b0;
    d.otp_rd = 1'b0;
    d.spi_go = 1'b0;
    unique case (q.st)
      S_HOLD: begin
        d.cnt = '0;
        if (q.rst_s2) d.st = S_IRST;
      end
      S_IRST: begin
        if (q.cnt == 16'(`BL_IRST_CYC - 1)) begin
          d.gpio_rel = 1'b1;
          d.pull_en = 1'b1;
          d.st = S_SELECT;
        end else begin
          d.cnt = q.cnt + 16'd1;
        end
      end
      S_SELECT: begin
        // select pins are taken once; later changes are not seen
        d.cnt = '0;
        d.bidx = '0;
        d.crc = `BL_CRC_INIT;
        d.addr = `BL_RAM_BASE;
        if (SECURITY_REG[`BL_SEC_BOOT_BIT]) begin
          d.src = SRC_OTP;
          d.otp_next = `BL_OTP_BASE;
          d.st = S_SIZE;
        end else if (!q.sel_s2[1]) begin
          d.jtag_wait = 1'b1;
          d.reserved = q.sel_s2[0];
          d.st = S_JTAG;
        end else begin
          d.tile1_chan = !q.sel_s2[2];
          d.int_links = q.sel_s2[2] && !q.sel_s2[0];
          if (q.sel_s2[0]) begin
            d.src = SRC_SPI;
            d.ss_act = 1'b1;
            d.st = S_SPI_CMD;
          end else begin
            d.src = SRC_LINK;
            d.st = S_LINK_WAIT;
          end
        end
      end
      S_JTAG: d.jtag_wait = 1'b1;
      S_LINK_WAIT: begin
        if (q.cnt == 16'(`BL_LINK_CYC - 1)) begin
          d.link_en = 1'b1;
          d.chan_alloc = 1'b1;
          d.st = S_ACK;
        end else begin
          d.cnt = q.cnt + 16'd1;
        end
      end
      S_SPI_CMD: begin
        if (!spi_busy && !q.spi_go) begin
          if (q.cnt == `BL_SPI_CMD_BYTES) begin
            d.st = S_SIZE;
          end else begin
            d.spi_go = 1'b1;
            d.spi_discard = 1'b1;
            d.spi_tx = (q.cnt == 16'd0) ? `BL_SPI_READ : 8'h00;
            d.cnt = q.cnt + 16'd1;
          end
        end
      end
      S_ACK, S_SIZE, S_PROG, S_CRC: begin
        if (pop) begin
          d.word = w;
          d.bidx = q.bidx + 2'd1;
          if ((q.st == S_SIZE) || (q.st == S_PROG)) begin
            d.crc = crc_byte(q.crc, buf_out.data[7:0]);
          end
          if (last) begin
            unique case (q.st)
              S_ACK: begin
                d.ack = w;
                d.st = S_SIZE;
              end
              S_SIZE: begin
                d.left = w;
                d.st = (w == 32'h0000_0000) ? S_CRC : S_PROG;
              end
              S_PROG: begin
                d.ram_we = 1'b1;
                d.ram_addr = q.addr;
                d.ram_data = w;
                d.addr = q.addr + 14'd1;
                d.left = q.left - 32'd1;
                if (q.left == 32'd1) d.st = S_CRC;
              end
              S_CRC: begin
                d.crc_err = (w != `BL_NO_CRC) && (w != ~q.crc);
                if (q.src == SRC_LINK) d.st = S_END_IN;
                else fin = 1'b1;
              end
              default: d.st = S_FAIL;
            endcase
          end
        end
      end
      S_END_IN: begin
        // data bytes before the end token are dropped
        if (pop && buf_out.data[8]) begin
          if (q.ack == `BL_NULL_CHAN) begin
            fin = 1'b1;
          end else begin
            d.tx_valid = 1'b1;
            d.st = S_END_OUT;
          end
        end
      end
      S_END_OUT: begin
        if (LINK_TX_READY) begin
          d.tx_valid = 1'b0;
          fin = 1'b1;
        end
      end
      S_RUN, S_FAIL: d.st = q.st;
      default: d.st = S_FAIL;
    endcase

    // end of load: release channel and flash, start only a good image
    if (fin) begin
      d.chan_alloc = 1'b0;
      d.ss_act = 1'b0;
      if (d.crc_err) begin
        d.fail = 1'b1;
        d.st = S_FAIL;
      end else begin
        d.exec = 1'b1;
        d.st = S_RUN;
      end
    end

    // fetch one byte ahead only while the buffer has room
    if ((q.src == SRC_SPI) && fetch_st && !fin && !spi_busy && !q.spi_go && buf_in.ready) begin
      d.spi_go = 1'b1;
      d.spi_discard = 1'b0;
      d.spi_tx = 8'h00;
    end
    if (OTP_VALID) d.otp_pend = 1'b0; // a read issued in the same cycle keeps pending set
    if ((q.src == SRC_OTP) && fetch_st && !fin && !q.otp_pend && buf_in.ready) begin
      d.otp_rd = 1'b1;
      d.otp_pend = 1'b1;
      d.otp_ra = q.otp_next;
      d.otp_next = q.otp_next + 13'd1;
    end

    // chip reset pin overrides everything but the synchronisers
    if (!q.rst_s2) begin
      w = 32'h0000_0000;
      d = '0;
      d.rst_s1 = CHIP_RST_N;
      d.rst_s2 = q.rst_s1;
      d.sel_s1 = BOOT_SEL;
      d.sel_s2 = q.sel_s1;
      d.miso_s1 = SPI_MISO;
      d.miso_s2 = q.miso_s1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) q <= '0;
    else if (CE) q <= d;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops or constants
  assign GPIO_HIZ = !q.gpio_rel;
  assign GPIO_PULL_EN = q.pull_en;
  assign BOOT_WAIT_JTAG = q.jtag_wait;
  assign BOOT_SEL_RESERVED = q.reserved;
  assign TILE1_VIA_CHAN0 = q.tile1_chan;
  assign INT_LINKS_EN = q.int_links;
  assign SPI_SS_N = !q.ss_act;
  assign LINK_EN = q.link_en;
  assign LINK_PD_EN = !q.link_en;
  assign LINK_TX_WIRE = 2'b00; // idle level of the outgoing wires
  assign LINK_TX_OE_N = !q.link_en;
  assign CHAN0_ALLOC = q.chan_alloc;
  assign LINK_TX_VALID = q.tx_valid;
  assign LINK_TX_DEST = q.ack;
  assign OTP_RD = q.otp_rd;
  assign OTP_ADDR = q.otp_ra;
  assign RAM_WE = q.ram_we;
  assign RAM_ADDR = q.ram_addr;
  assign RAM_WDATA = q.ram_data;
  assign START_EXEC = q.exec;
  assign START_ADDR = `BL_RAM_BASE;
  assign CRC_ERROR = q.crc_err;
  assign BOOT_FAIL = q.fail;

  ////////////////////////////////////////////////////////////////////////
  // checks; a frozen clock enable would stretch every figure
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST || !CE);

  pins_float_a: assert property (!q.rst_s2 |=> GPIO_HIZ && !GPIO_PULL_EN)
    else $error("pins not floating in chip reset");
  pull_delay_a: assert property ($rose(GPIO_PULL_EN) |->
      $past(q.st == S_IRST) && ($past(q.cnt) == 16'(`BL_IRST_CYC - 1)))
    else $error("pulls enabled before the internal reset time");
  jtag_wait_a: assert property ((q.st == S_SELECT) && q.rst_s2 &&
      !SECURITY_REG[`BL_SEC_BOOT_BIT] && !q.sel_s2[1] |=> BOOT_WAIT_JTAG)
    else $error("no-boot setting did not wait");
  secure_src_a: assert property ((q.st == S_SELECT) && q.rst_s2 &&
      SECURITY_REG[`BL_SEC_BOOT_BIT] |=> (q.src == SRC_OTP) && (q.st == S_SIZE))
    else $error("secure bit did not force otp boot");
  link_delay_a: assert property ($rose(q.st == S_LINK_WAIT) && q.rst_s2 |->
      !LINK_EN ##25 LINK_EN)
    else $error("link enable not 25 cycles after boot start");
  spi_idle_a: assert property (SPI_SS_N |-> !SPI_SCLK)
    else $error("serial clock not idle low while deselected");
  ram_base_a: assert property ($rose(q.st == S_PROG) |-> (q.addr == `BL_RAM_BASE))
    else $error("load does not start at ram base");
  crc_gate_a: assert property (START_EXEC |-> !CRC_ERROR)
    else $error("program started after crc mismatch");
  null_ack_a: assert property ((q.st == S_END_IN) && pop && buf_out.data[8] && q.rst_s2 &&
      (q.ack == `BL_NULL_CHAN) |=> !LINK_TX_VALID && !CHAN0_ALLOC)
    else $error("end token sent to null channel");
  end_hold_a: assert property (LINK_TX_VALID && !LINK_TX_READY && q.rst_s2 |=>
      LINK_TX_VALID)
    else $error("end token withdrawn before taken");
endmodule : multi_source_boot_loader

// ---- design/spi_boot_master.sv ----
// mode 0 serial master: one byte per request, command out msb first, data in lsb first
`timescale 1ns/1ps
`include "boot_map.svh"
module spi_boot_master (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic go,
  input wire logic discard,
  input wire logic [7:0] tx,
  input wire logic miso,
  output logic busy,
  output logic sclk,
  output logic mosi,
  byte_if.src rx
);
  typedef struct packed {
    logic busy;
    logic hold;
    logic discard;
    logic sclk;
    logic [2:0] bitn;
    logic [7:0] div;
    logic [7:0] txs;
    logic [7:0] rxs;
  } spi_t;
  spi_t q, d;

  ////////////////////////////////////////////////////////////////////////
  assign busy = q.busy;
  assign sclk = q.sclk;
  assign mosi = q.txs[7];
  assign rx.valid = q.hold;
  assign rx.data = {1'b0, q.rxs};

  // half period of 25 cycles gives the boot serial clock
  always_comb begin
    d = q;
    if (q.hold) begin
      if (rx.ready) begin // byte held until the buffer takes it
        d.hold = 1'b0;
        d.busy = 1'b0;
      end
    end else if (!q.busy) begin
      if (go) begin
        d.busy = 1'b1;
        d.discard = discard;
        d.txs = tx;
        d.div = '0;
        d.bitn = '0;
      end
    end else if (q.div == 8'(`BL_SCLK_HALF - 1)) begin
      d.div = '0;
      if (!q.sclk) begin
        d.sclk = 1'b1;
        d.rxs = {miso, q.rxs[7:1]};
      end else begin
        d.sclk = 1'b0;
        d.txs = {q.txs[6:0], 1'b0};
        d.bitn = q.bitn + 3'd1;
        if (q.bitn == 3'd7) begin
          if (q.discard) d.busy = 1'b0;
          else d.hold = 1'b1;
        end
      end
    end else begin
      d.div = q.div + 8'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) q <= '0;
    else if (ce) q <= d;
  end
endmodule : spi_boot_master

// ---- verif/spi_flash_model.sv ----
// serial flash partner: mode 0 slave returning the boot image lsb first
`timescale 1ns/1ps
module spi_flash_model (
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso
);
  logic [7:0] mem [0:63];
  logic [31:0] cmd = 32'h0000_0000;
  logic out_q = 1'b0;
  int bit_cnt = 0;
  ////////////////////////////////////////////////////////////////////////////
  // a new select restarts the command phase
  always @(negedge ss_n) begin
    bit_cnt = 0;
  end
  // command and address are taken msb first on the rising edge
  always @(posedge sclk) begin
    if (!ss_n && bit_cnt < 32) cmd = {cmd[30:0], mosi};
    if (!ss_n) bit_cnt = bit_cnt + 1;
  end
  // image bits change on the falling edge so they are stable at the rise
  always @(negedge sclk) begin
    if (!ss_n && bit_cnt >= 32) out_q = mem[(bit_cnt - 32) / 8][(bit_cnt - 32) % 8];
  end
  // no pull on the data line: a deselected flash shows the inverse
  assign miso = ss_n ? ~out_q : out_q;
endmodule : spi_flash_model

// ---- verif/tb_top.sv ----
// self-checking bench of the boot sequencer over spi, link, otp and test-port modes
`timescale 1ns/1ps
`include "boot_map.svh"
module tb_top;
  logic CLK_SYS = 0, RST = 1, CE = 1, CHIP_RST_N = 0, SPI_MISO;
  logic [2:0] BOOT_SEL = 0;
  logic [31:0] SECURITY_REG = 0;
  logic LINK_RX_VALID = 0, LINK_RX_CTRL = 0, LINK_TX_READY = 0, OTP_VALID = 0;
  logic [7:0] LINK_RX_DATA = 0, OTP_DATA = 0;
  logic GPIO_HIZ, GPIO_PULL_EN, BOOT_WAIT_JTAG, BOOT_SEL_RESERVED, TILE1_VIA_CHAN0;
  logic INT_LINKS_EN, SPI_SS_N, SPI_SCLK, SPI_MOSI, LINK_EN, LINK_PD_EN, LINK_TX_OE_N;
  logic CHAN0_ALLOC, LINK_RX_READY, LINK_TX_VALID, OTP_RD, RAM_WE, START_EXEC;
  logic CRC_ERROR, BOOT_FAIL;
  logic [1:0] LINK_TX_WIRE;
  logic [31:0] LINK_TX_DEST, RAM_WDATA;
  logic [12:0] OTP_ADDR, otp_a;
  logic [13:0] RAM_ADDR, START_ADDR;
  logic [7:0] img [0:63];
  logic [45:0] ram_q [$];
  logic [31:0] lfsr_st = 32'h0001_47B6;
  logic tx_seen = 0, ss_seen = 0;
  time sclk_t = 0, sclk_min = 1000000;
  int error_cnt = 0, compares = 0, nw = 0;
  ////////////////////////////////////////////////////////////////////////////
  multi_source_boot_loader i_dut (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE),
    .CHIP_RST_N(CHIP_RST_N), .BOOT_SEL(BOOT_SEL), .SECURITY_REG(SECURITY_REG),
    .GPIO_HIZ(GPIO_HIZ), .GPIO_PULL_EN(GPIO_PULL_EN), .BOOT_WAIT_JTAG(BOOT_WAIT_JTAG),
    .BOOT_SEL_RESERVED(BOOT_SEL_RESERVED), .TILE1_VIA_CHAN0(TILE1_VIA_CHAN0),
    .INT_LINKS_EN(INT_LINKS_EN), .SPI_MISO(SPI_MISO), .SPI_SS_N(SPI_SS_N),
    .SPI_SCLK(SPI_SCLK), .SPI_MOSI(SPI_MOSI), .LINK_EN(LINK_EN), .LINK_PD_EN(LINK_PD_EN),
    .LINK_TX_WIRE(LINK_TX_WIRE), .LINK_TX_OE_N(LINK_TX_OE_N), .CHAN0_ALLOC(CHAN0_ALLOC),
    .LINK_RX_VALID(LINK_RX_VALID), .LINK_RX_DATA(LINK_RX_DATA),
    .LINK_RX_CTRL(LINK_RX_CTRL), .LINK_RX_READY(LINK_RX_READY),
    .LINK_TX_VALID(LINK_TX_VALID), .LINK_TX_DEST(LINK_TX_DEST),
    .LINK_TX_READY(LINK_TX_READY), .OTP_RD(OTP_RD), .OTP_ADDR(OTP_ADDR),
    .OTP_VALID(OTP_VALID), .OTP_DATA(OTP_DATA), .RAM_WE(RAM_WE), .RAM_ADDR(RAM_ADDR),
    .RAM_WDATA(RAM_WDATA), .START_EXEC(START_EXEC), .START_ADDR(START_ADDR),
    .CRC_ERROR(CRC_ERROR), .BOOT_FAIL(BOOT_FAIL));
  spi_flash_model i_flash (.sclk(SPI_SCLK), .ss_n(SPI_SS_N), .mosi(SPI_MOSI),
    .miso(SPI_MISO));
  ////////////////////////////////////////////////////////////////////////////
  always #4 CLK_SYS = ~CLK_SYS;
  // outputs are sampled at the falling edge, well clear of register updates
  always @(negedge CLK_SYS) begin
    if (LINK_TX_VALID === 1'b1) tx_seen = 1;
    if (SPI_SS_N === 1'b0) ss_seen = 1;
    if (RAM_WE === 1'b1) ram_q.push_back({RAM_ADDR, RAM_WDATA});
  end
  // shortest serial clock period; gaps between bytes only make it longer
  always @(posedge SPI_SCLK) begin
    if ($time - sclk_t < sclk_min) sclk_min = $time - sclk_t;
    sclk_t = $time;
  end
  // otp answers each read two cycles later, one read outstanding
  always @(negedge CLK_SYS) begin
    if (OTP_RD === 1'b1) begin
      otp_a = OTP_ADDR;
      repeat (2) @(posedge CLK_SYS);
      #1 OTP_VALID = 1;
      OTP_DATA = img[otp_a];
      @(posedge CLK_SYS);
      #1 OTP_VALID = 0;
      OTP_DATA = ~OTP_DATA;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next();
    for (int i = 0; i < 32; i++) begin
      lfsr_st = lfsr_st[0] ? (lfsr_st >> 1) ^ 32'hA300_0000 : lfsr_st >> 1;
    end
    return lfsr_st;
  endfunction : lfsr_next
  // reflected crc over count and program bytes, inverted at the end
  function automatic logic [31:0] crc_of(input int n);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    for (int i = 0; i < n; i++) begin
      c = c ^ img[i];
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
    end
    return ~c;
  endfunction : crc_of
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // image: count lsb first, words, crc field (mode 1 skip marker, 2 corrupt)
  task automatic build(input int n, input int mode);
    logic [31:0] c;
    nw = n;
    for (int i = 0; i < 4; i++) img[i] = 8'(n >> (8 * i));
    for (int i = 4; i < 4 * n + 4; i++) img[i] = 8'(lfsr_next());
    c = mode == 1 ? `BL_NO_CRC : crc_of(4 * n + 4) ^ (mode == 2 ? 32'h0000_0100 : 32'h0);
    for (int i = 0; i < 4; i++) img[4 * n + 4 + i] = 8'(c >> (8 * i));
    for (int i = 0; i < 64; i++) i_flash.mem[i] = img[i];
  endtask : build
  task automatic boot(input logic [2:0] sel, input logic sec);
    int k;
    logic [31:0] r;
    r = lfsr_next();
    @(posedge CLK_SYS);
    #1 CHIP_RST_N = 0;
    BOOT_SEL = sel;
    SECURITY_REG = {r[31:6], sec, r[4:0]};
    repeat (6) @(negedge CLK_SYS);
    check({GPIO_HIZ, GPIO_PULL_EN, START_EXEC, SPI_SS_N, LINK_EN}, 5'b10010);
    ram_q.delete();
    tx_seen = 0;
    ss_seen = 0;
    @(posedge CLK_SYS);
    #1 CHIP_RST_N = 1;
    for (k = 0; k < 3000 && GPIO_PULL_EN !== 1'b1; k++) @(negedge CLK_SYS);
    check(k >= `BL_IRST_CYC && k <= `BL_IRST_CYC + 6, 1);
    check(GPIO_HIZ, 0);
  endtask : boot
  task automatic finish_boot(input int mode);
    int k;
    logic [2:0] e;
    logic [31:0] w;
    e = (mode == 2) ? 3'b011 : 3'b100;
    for (k = 0; k < 20000 && START_EXEC !== 1'b1 && BOOT_FAIL !== 1'b1; k++) @(negedge CLK_SYS);
    check({START_EXEC, CRC_ERROR, BOOT_FAIL, START_ADDR}, {e, 14'h0});
    if (mode != 2) check(ram_q.size(), nw);
    foreach (ram_q[i]) begin
      w = {img[4*i+7], img[4*i+6], img[4*i+5], img[4*i+4]};
      if (mode != 2) check(ram_q[i], {i[13:0], w});
    end
  endtask : finish_boot
  // one link byte, held until the edge at which ready is high
  task automatic send(input logic [7:0] d, input logic ctl);
    @(posedge CLK_SYS);
    #1 LINK_RX_VALID = 1;
    LINK_RX_DATA = d;
    LINK_RX_CTRL = ctl;
    for (int k = 0; k < 2000; k++) begin
      @(negedge CLK_SYS);
      if (LINK_RX_READY === 1'b1) break;
    end
    @(posedge CLK_SYS);
    #1 LINK_RX_VALID = 0;
    LINK_RX_DATA = ~d;
    LINK_RX_CTRL = 0;
  endtask : send
  task automatic run_link(input logic [2:0] sel, input logic [31:0] ack);
    int k;
    logic nul;
    nul = (ack == `BL_NULL_CHAN);
    build(1 + lfsr_next() % 4, 0);
    boot(sel, 0);
    // incoming side stays idle until the link is enabled
    for (k = 0; k < 100 && LINK_EN !== 1'b1; k++) @(negedge CLK_SYS);
    check(k >= `BL_LINK_CYC && k <= `BL_LINK_CYC + 4, 1);
    check({LINK_PD_EN, LINK_TX_OE_N, LINK_TX_WIRE, CHAN0_ALLOC}, 5'b00001);
    check({TILE1_VIA_CHAN0, INT_LINKS_EN}, {~sel[2], sel[2]});
    for (int i = 0; i < 4; i++) send(ack[8 * i +: 8], 0);
    for (int i = 0; i < 4 * nw + 8; i++) send(img[i], 0);
    send(8'h01, 1);
    repeat (10) @(negedge CLK_SYS);
    check({tx_seen, LINK_TX_VALID, START_EXEC}, {!nul, !nul, nul});
    if (ack != `BL_NULL_CHAN) check(LINK_TX_DEST, ack);
    @(posedge CLK_SYS);
    #1 LINK_TX_READY = 1;
    finish_boot(0);
    check(CHAN0_ALLOC, 0);
    @(posedge CLK_SYS);
    #1 LINK_TX_READY = 0;
  endtask : run_link
  ////////////////////////////////////////////////////////////////////////////
  // main sequence: test-port modes, spi, otp, link
  initial begin
    repeat (6) @(posedge CLK_SYS);
    #1 RST = 0;
    for (int s = 0; s < 8; s++) if (s[1] == 0) begin
      boot(3'(s), 0);
      repeat (20) @(negedge CLK_SYS);
      check({BOOT_WAIT_JTAG, BOOT_SEL_RESERVED, ss_seen, LINK_EN, START_EXEC},
        {1'b1, s[0], 3'b000});
      $display("test wait %0d done", s);
    end
    for (int s = 3; s < 8; s += 4) begin
      build(1 + lfsr_next() % 4, 0);
      boot(3'(s), 0);
      finish_boot(0);
      check({i_flash.cmd, TILE1_VIA_CHAN0, INT_LINKS_EN}, {32'h0300_0000, s < 4, 1'b0});
      check(sclk_min, 2 * `BL_SCLK_HALF * `BL_CLK_NS);
      $display("test spi %0d done", s);
    end
    for (int m = 1; m < 3; m++) begin
      build(m == 1 ? 2 + lfsr_next() % 3 : 0, m);
      boot(3'b011, 1);
      finish_boot(m);
      check({ss_seen, LINK_EN}, 2'b00);
      $display("test otp %0d done", m);
    end
    run_link(3'b010, lfsr_next() | 32'h0000_0001);
    $display("test link ack done");
    run_link(3'b110, `BL_NULL_CHAN);
    $display("test link null done");
    stop_test();
  end
  // watchdog well beyond the expected run of some 40000 cycles
  initial begin
    #(8 * 90000);
    error_cnt++;
    stop_test();
  end
endmodule : tb_top
